/* File: design/pdss_slave.sv */
// Purpose: Configuration memory slave end of the two-wire link.
// Assumes: Serial clock is far slower than clock; lines sampled by two flops.
// Notes:   Array write bytes pass a FIFO into the array; array reads come from it, protection reads from the lock flag.
module pdss_slave #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  rst_n,
  // Link
  pdss_if.slave_mp   link,
  // Straps and status
  input  wire logic  chip_enable_bit0,
  input  wire logic  chip_enable_bit1,
  input  wire logic  chip_enable_bit2,
  input  wire logic  write_protect_input,
  output logic       standby,
  output logic       prot_locked
);
  typedef enum logic [2:0] {PDSS_IDLE, PDSS_SEL, PDSS_ADDR, PDSS_WDATA, PDSS_RDATA, PDSS_RACK, PDSS_WAIT}
    pdss_state_t;
  // ****************************************
  // Line synchronisers and condition detect
  // ****************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], link.scl_line};
      sda_sync <= {sda_sync[0], link.sda_line};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end
  // Conditions are judged only on the second flop and its delayed copy.
  wire scl_rise  = scl_sync[1] & ~scl_q;
  wire scl_fall  = ~scl_sync[1] & scl_q;
  wire start_det = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  wire stop_det  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  // ****************************************
  // Byte engine
  // ****************************************
  pdss_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  addr;
  logic        prot_sel;
  logic        drive_low;
  logic        first_wr;
  logic [7:0]  mem [pdss_pkg::PDSS_MEM_WORDS];
  wire  [2:0]  straps = {chip_enable_bit2, chip_enable_bit1, chip_enable_bit0};
  wire  [7:0]  rx_byte = {shreg[6:0], sda_sync[1]};
  wire  [3:0]  sel_type = rx_byte[pdss_pkg::PDSS_TYPE_MSB:pdss_pkg::PDSS_TYPE_LSB];
  wire         is_mem  = sel_type == pdss_pkg::PDSS_TYPE_MEM;
  wire         is_prot = sel_type == pdss_pkg::PDSS_TYPE_PROT;
  wire         sel_hit = (is_mem | is_prot) &&
                         rx_byte[pdss_pkg::PDSS_CE_MSB:pdss_pkg::PDSS_CE_LSB] == straps;
  wire         byte_done = scl_rise && bit_cnt == 4'(pdss_pkg::PDSS_BITS - 1);
  wire         ack_slot  = bit_cnt == 4'(pdss_pkg::PDSS_BITS);
  // The count parks one past the acknowledge slot until the clock falls again.
  // That way the ninth rise and the ninth fall can be told apart.
  wire  [3:0]  ack_end   = 4'(pdss_pkg::PDSS_BITS + 1);
  // Next bit to shift out; after the acknowledge slot the byte restarts at its top bit.
  wire  [2:0]  tx_idx    = bit_cnt < 4'(pdss_pkg::PDSS_BITS) ? bit_cnt[2:0] : 3'h0;
  // The protection register reads back with its lock flag in the top bit.
  wire         mem_bit   = prot_sel ? (tx_idx == 3'h0 && prot_locked) :
                           mem[addr][3'(pdss_pkg::PDSS_BITS - 1) - tx_idx];
  // Write path through the FIFO; the write-protect input blocks array writes, a set lock does not.
  logic        wf_valid;
  logic        wf_ready;
  logic [15:0] wf_in;
  logic        wo_valid;
  logic [15:0] wo_data;
  wire         wr_block = write_protect_input | (prot_sel & prot_locked);
  pdss_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (wf_valid),
    .in_ready  (wf_ready),
    .in_data   (wf_in),
    .out_valid (wo_valid),
    .out_ready (1'b1),
    .out_data  (wo_data)
  );
  always_ff @(posedge clock) begin
    if (wo_valid) mem[wo_data[15:8]] <= wo_data[7:0];
  end
  // Protocol sequencer; start and stop override any state.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state     <= PDSS_IDLE;
      bit_cnt   <= '0;
      shreg     <= '0;
      addr      <= pdss_pkg::PDSS_ADDR_RST;
      prot_sel  <= 1'b0;
      drive_low <= 1'b0;
      first_wr  <= 1'b0;
      wf_valid  <= 1'b0;
      wf_in     <= '0;
      standby   <= 1'b1;
      prot_locked <= 1'b0;
    end else begin
      wf_valid <= 1'b0;
      if (start_det) begin
        state     <= PDSS_SEL;
        bit_cnt   <= '0;
        drive_low <= 1'b0;
        standby   <= 1'b0;
      end else if (stop_det) begin
        state     <= PDSS_IDLE;
        drive_low <= 1'b0;
        standby   <= 1'b1;
      end else if (state != PDSS_IDLE && state != PDSS_WAIT) begin
        if (scl_rise && bit_cnt < 4'(pdss_pkg::PDSS_BITS)) begin
          shreg   <= rx_byte;
          bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_rise && ack_slot) begin
          bit_cnt <= ack_end;
        end
        if (byte_done) begin
          unique case (state)
            PDSS_SEL: begin
              prot_sel <= is_prot;
              if (!sel_hit) state <= PDSS_WAIT;
              else if (rx_byte[pdss_pkg::PDSS_RW_BIT]) state <= PDSS_RDATA;
              else state <= PDSS_ADDR;
            end
            PDSS_ADDR: begin
              addr     <= rx_byte;
              first_wr <= 1'b1;
              state    <= PDSS_WDATA;
            end
            PDSS_WDATA: begin
              if (!wr_block && !prot_sel && wf_ready) begin
                wf_valid <= 1'b1;
                wf_in    <= {addr, rx_byte};
              end
              if (prot_sel && !write_protect_input) prot_locked <= 1'b1;
              addr <= addr + 8'h01;
            end
            PDSS_RDATA: state <= PDSS_RACK;
            default: ;
          endcase
        end
        if (scl_rise && ack_slot && state == PDSS_RACK) begin
          // Data low on the ninth clock means the master wants more.
          if (!sda_sync[1]) begin
            state <= PDSS_RDATA;
            addr  <= addr + 8'h01;
          end else begin
            state <= PDSS_WAIT;
          end
        end
        // Data only moves after the clock has fallen.
        // Waiting for the fall keeps a data change from looking like a start or stop.
        if (scl_fall) begin
          if (bit_cnt == ack_end) begin
            bit_cnt   <= '0;
            drive_low <= state == PDSS_RDATA && !mem_bit;
          end else if (ack_slot) begin
            drive_low <= state != PDSS_RACK;
          end else if (state == PDSS_RDATA) begin
            drive_low <= ~mem_bit;
          end
        end
      end
    end
  end
  // Open drain: enable and low level together.
  // The slave never drives high, so a clash with the host cannot short the line.
  assign link.sda_oe_s  = drive_low;
  assign link.sda_out_s = 1'b0;
endmodule : pdss_slave

/* File: design/pdss_pkg.sv */
// Purpose: Shared constants for the two-wire configuration memory link.
// Assumes: One system clock at 50 MHz on both ends.
// Notes:   Offsets, codes and counts live here so both ends agree.
package pdss_pkg;
  // ****************************************
  // Select byte layout
  // ****************************************
  localparam logic [3:0] PDSS_TYPE_MEM  = 4'hA;   // Main array type code.
  localparam logic [3:0] PDSS_TYPE_PROT = 4'h6;   // Protection register type code.
  localparam int         PDSS_TYPE_MSB  = 7;
  localparam int         PDSS_TYPE_LSB  = 4;
  localparam int         PDSS_CE_MSB    = 3;
  localparam int         PDSS_CE_LSB    = 1;
  localparam int         PDSS_RW_BIT    = 0;
  localparam int         PDSS_BITS      = 8;
  // ****************************************
  // Timing
  // ****************************************
  localparam int         PDSS_CLK_NS    = 20;
  localparam int         PDSS_QTR_NS    = 2500;   // Quarter of the serial clock period.
  localparam int         PDSS_QTR_CYC   = (PDSS_QTR_NS + PDSS_CLK_NS - 1) / PDSS_CLK_NS;
  localparam int         PDSS_MEM_WORDS = 256;
  localparam logic [7:0] PDSS_ADDR_RST  = 8'h00;
endpackage : pdss_pkg

/* File: design/pdss_if.sv */
// Purpose: Two-wire link between the host master and the memory slave.
// Assumes: Open-drain wires with pull-ups; enables high mean pull low.
// Notes:   The wire levels are resolved here from both ends' enables.
interface pdss_if;
  logic scl_oe_m;   // Master pulls the clock low.
  logic sda_oe_m;   // Master pulls the data low.
  logic sda_oe_s;   // Slave pulls the data low.
  logic scl_out_m;
  logic sda_out_m;
  logic sda_out_s;
  wire  scl_line = ~(scl_oe_m & ~scl_out_m);
  wire  sda_line = ~((sda_oe_m & ~sda_out_m) | (sda_oe_s & ~sda_out_s));
  modport host_mp  (output scl_oe_m, sda_oe_m, scl_out_m, sda_out_m, input scl_line, sda_line);
  modport slave_mp (output sda_oe_s, sda_out_s, input scl_line, sda_line);
endinterface : pdss_if

/* File: design/pdss_fifo.sv */
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: Single clock.
// Notes:   Depth must be a power of two.
module pdss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  // Full when pointers differ only in the wrap bit.
  assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  // Pointer update.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
  // Storage has no reset, to stay a plain memory.
  always_ff @(posedge clock) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : pdss_fifo

/* File: design/pdss_host.sv */
// Purpose: Host master end that runs select, address, write and read bytes.
// Assumes: Serial clock made from clock by a divider of four phases.
// Notes:   One command at a time; results come back one byte per pulse.
module pdss_host (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Link
  pdss_if.host_mp         link,
  // Command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [7:0] cmd_select,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic [4:0] cmd_count,
  // Results
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            nack_seen
);
  typedef enum logic [2:0] {PDSSH_IDLE, PDSSH_START, PDSSH_BYTE, PDSSH_ACK, PDSSH_STOP} pdssh_state_t;
  // ****************************************
  // Quarter-period enable
  // ****************************************
  logic [15:0] div;
  wire         tick = div == 16'(pdss_pkg::PDSS_QTR_CYC - 1);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) div <= '0;
    else div <= tick ? 16'h0000 : div + 16'h0001;
  end
  logic [1:0] sda_sync;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sda_sync <= 2'h3;
    else sda_sync <= {sda_sync[0], link.sda_line};
  end
  // ****************************************
  // Sequencer: phase 0 data set, 1 high, 2 sample, 3 low edge
  // ****************************************
  pdssh_state_t state;
  logic [1:0]   ph;
  logic [2:0]   bit_n;
  logic [1:0]   stage;      // 0 select, 1 address, 2 data.
  logic [4:0]   left;
  logic [7:0]   tx;
  logic [7:0]   rx;
  logic         reading;
  logic         scl_low;
  logic         sda_low;
  wire          rd_mode = cmd_select[pdss_pkg::PDSS_RW_BIT];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= PDSSH_IDLE; ph <= '0; bit_n <= '0; stage <= '0; left <= '0;
      tx <= '0; rx <= '0; reading <= 1'b0; scl_low <= 1'b0; sda_low <= 1'b0;
      cmd_ready <= 1'b1; rd_valid <= 1'b0; rd_data <= '0; nack_seen <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (state == PDSSH_IDLE && cmd_valid && cmd_ready) begin
        cmd_ready <= 1'b0;
        nack_seen <= 1'b0;
        left      <= cmd_count;
        state     <= PDSSH_START;
        ph        <= '0;
      end else if (tick && state != PDSSH_IDLE) begin
        ph <= ph + 2'h1;
        unique case (state)
          PDSSH_START: if (ph == 2'h1) begin
            sda_low <= 1'b1;
          end else if (ph == 2'h3) begin
            scl_low <= 1'b1; tx <= cmd_select; stage <= '0; bit_n <= '0; reading <= 1'b0;
            state <= PDSSH_BYTE;
          end
          PDSSH_BYTE: begin
            if (ph == 2'h0) sda_low <= reading ? 1'b0 : ~tx[7];
            if (ph == 2'h1) scl_low <= 1'b0;
            if (ph == 2'h2) rx <= {rx[6:0], sda_sync[1]};
            if (ph == 2'h3) begin
              scl_low <= 1'b1; tx <= {tx[6:0], 1'b0}; bit_n <= bit_n + 3'h1;
              if (bit_n == 3'h7) state <= PDSSH_ACK;
            end
          end
          PDSSH_ACK: begin
            // Reading, the host acknowledges unless this is the last byte.
            if (ph == 2'h0) sda_low <= reading && left > 5'h1;
            if (ph == 2'h1) scl_low <= 1'b0;
            if (ph == 2'h2) begin
              if (!reading && sda_sync[1]) nack_seen <= 1'b1;
              if (reading) begin rd_valid <= 1'b1; rd_data <= rx; end
            end
            if (ph == 2'h3) begin
              scl_low <= 1'b1; bit_n <= '0;
              if (nack_seen) state <= PDSSH_STOP;
              else if (stage == 2'h0 && rd_mode) begin reading <= 1'b1; stage <= 2'h2; state <= PDSSH_BYTE; end
              else if (stage == 2'h0) begin tx <= cmd_addr; stage <= 2'h1; state <= PDSSH_BYTE; end
              else if (stage == 2'h1 && left != 5'h0) begin tx <= cmd_wdata; stage <= 2'h2; state <= PDSSH_BYTE; end
              else if (reading && left > 5'h1) begin left <= left - 5'h1; state <= PDSSH_BYTE; end
              else state <= PDSSH_STOP;
            end
          end
          PDSSH_STOP: begin
            if (ph == 2'h0) sda_low <= 1'b1;
            if (ph == 2'h1) scl_low <= 1'b0;
            if (ph == 2'h3) begin
              sda_low <= 1'b0;
              state <= PDSSH_IDLE; cmd_ready <= 1'b1;
            end
          end
          default: state <= PDSSH_IDLE;
        endcase
      end
    end
  end
  assign link.scl_oe_m  = scl_low;
  assign link.sda_oe_m  = sda_low;
  assign link.scl_out_m = 1'b0;
  assign link.sda_out_m = 1'b0;
endmodule : pdss_host

/* File: verif/pdss_monitor.sv */
// Purpose: Watches the two-wire link that joins the host and slave ends.
// Assumes: Lines are sampled on clock; the serial clock is far slower than clock.
// Notes:   Helper flops track framing, the bit count and the select byte.
module pdss_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link signals
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic scl_line,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q, sda_q, in_frame, seen_start, first, acked, rd_mode, nacked;
  logic [3:0] cnt;
  logic [7:0] sh;

  // Edge decode; the ninth rise of a byte is the acknowledge slot.
  wire start_w = scl_line & scl_q & sda_q & ~sda_line;
  wire stop_w  = scl_line & scl_q & ~sda_q & sda_line;
  wire rise_w  = scl_line & ~scl_q;
  wire ack_w   = rise_w & (cnt == 4'h8);
  wire type_ok = (sh[7:4] == pdss_pkg::PDSS_TYPE_MEM) | (sh[7:4] == pdss_pkg::PDSS_TYPE_PROT);

  // A restart clears the select state, so a random read is judged by its second select.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {scl_q, sda_q, in_frame, seen_start, first, acked, rd_mode, nacked} <= 8'hC0;
      cnt <= 4'h0;
      sh  <= 8'h00;
    end else begin
      scl_q <= scl_line;
      sda_q <= sda_line;
      if (start_w) begin
        {in_frame, seen_start, first, acked, nacked} <= 5'h1C;
        cnt <= 4'h0;
      end else if (stop_w) begin
        {in_frame, first, acked, nacked} <= 4'h0;
      end else if (rise_w) begin
        cnt <= ack_w ? 4'h0 : cnt + 4'h1;
        sh  <= {sh[6:0], sda_line};
        if (ack_w) begin
          first <= 1'b0;
          if (first) begin
            acked   <= sda_oe_s;
            rd_mode <= sh[0];
          end else if (rd_mode & acked & sda_line) begin
            nacked <= 1'b1;
          end
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence stop_s;
    scl_line && $rose(sda_line);
  endsequence
  sequence sel_ack_s;
    ack_w && first && sda_oe_s;
  endsequence

  a_slave_change_low:
    assert property ($changed(sda_oe_s) |-> !scl_line) else $error("slave data moved while clock high");
  a_clock_in_frame:
    assert property ($fell(scl_line) |-> in_frame) else $error("serial clock ran without a start");
  a_quiet_before_start:
    assert property (!seen_start |-> !sda_oe_s) else $error("slave drove data before any start");
  a_idle_clock_high:
    assert property (!in_frame |-> scl_line) else $error("serial clock low outside a frame");
  a_stop_releases:
    assert property (stop_s |=> !sda_oe_s [*8]) else $error("slave drove data after stop");
  a_one_driver:
    assert property (scl_line |-> !(sda_oe_m && sda_oe_s)) else $error("both ends drove data");
  a_select_type:
    assert property (sel_ack_s |-> type_ok) else $error("select acknowledged with a bad type code");
  a_write_acks:
    assert property (ack_w && !first && acked && !rd_mode |-> sda_oe_s) else $error("written byte not acknowledged");
  a_read_turn:
    assert property (ack_w && !first && acked && rd_mode |-> !sda_oe_s) else $error("slave held data in read ack slot");
  a_nack_quiet:
    assert property (nacked |-> !sda_oe_s) else $error("slave sent data after a no-acknowledge");
  a_unselected_quiet:
    assert property (in_frame && !first && !acked |-> !sda_oe_s) else $error("unselected slave drove data");
endmodule : pdss_monitor

/* File: verif/pdss_test.sv */
// Purpose: Runs host commands against the slave across the shared link.
// Assumes: Inputs change on the falling edge; each command ends with a stop.
// Notes:   Read bytes are gathered in a queue and compared after each command.
module pdss_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, rst_n, cmd_valid, cmd_ready, rd_valid, nack_seen, wp, standby, prot_locked;
  logic [7:0] cmd_select, cmd_addr, cmd_wdata, rd_data;
  logic [4:0] cmd_count;
  logic [2:0] ce;
  logic [7:0] rx[$];
  logic [7:0] bad_sel[2] = '{8'hA1, 8'h5B};
  int         err_count;
  int         cmp_count;

  pdss_if link_if ();
  pdss_host pdss_host_inst (.clock(clock), .rst_n(rst_n), .link(link_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_select(cmd_select), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_count(cmd_count), .rd_valid(rd_valid), .rd_data(rd_data), .nack_seen(nack_seen));
  pdss_slave #(.FIFO_DEPTH(16)) pdss_slave_inst (.clock(clock), .rst_n(rst_n), .link(link_if),
    .chip_enable_bit0(ce[0]), .chip_enable_bit1(ce[1]), .chip_enable_bit2(ce[2]),
    .write_protect_input(wp), .standby(standby), .prot_locked(prot_locked));
  pdss_monitor pdss_monitor_inst (.clock(clock), .rst_n(rst_n), .sda_oe_m(link_if.sda_oe_m),
    .sda_oe_s(link_if.sda_oe_s), .scl_line(link_if.scl_line), .sda_line(link_if.sda_line));

  // Clock of 20 ns.
  always #10 clock = ~clock;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // One command; read bytes are caught at the falling edge, where each pulse stands once.
  task automatic run(input logic [7:0] sel, input logic [7:0] addr, input logic [7:0] wd, input logic [4:0] n);
    while (cmd_ready !== 1'b1) @(negedge clock);
    rx.delete();
    cmd_select = sel;
    cmd_addr   = addr;
    cmd_wdata  = wd;
    cmd_count  = n;
    cmd_valid  = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    @(negedge clock);
    while (cmd_ready !== 1'b1) begin
      if (rd_valid === 1'b1) rx.push_back(rd_data);
      @(negedge clock);
    end
    // Let the slave's line synchronisers see the stop before anything is checked.
    repeat (4) @(negedge clock);
  endtask : run

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    {cmd_valid, cmd_select, cmd_addr, cmd_wdata, cmd_count} = '0;
    ce = 3'h0;
    wp = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    check({6'h00, standby, prot_locked}, 8'h02);
    // Two writes to neighbouring bytes; the straps move between them.
    run(8'hA0, 8'h10, 8'h5A, 5'h01);
    check({7'h00, nack_seen}, 8'h00);
    ce = 3'h5;
    run(8'hAA, 8'h11, 8'hC3, 5'h01);
    check({7'h00, nack_seen}, 8'h00);
    check({7'h00, standby}, 8'h01);
    // An address-only write moves the pointer back, then a two-byte read follows.
    run(8'hAA, 8'h10, 8'h00, 5'h00);
    check({7'h00, nack_seen}, 8'h00);
    run(8'hAB, 8'h10, 8'h00, 5'h02);
    check(8'(rx.size()), 8'h02);
    check(rx[0], 8'h5A);
    check(rx[1], 8'hC3);
    // A strap mismatch and a foreign type code must both go unanswered.
    foreach (bad_sel[i]) begin
      run(bad_sel[i], 8'h10, 8'h00, 5'h01);
      check({7'h00, nack_seen}, 8'h01);
      check(8'(rx.size()), 8'h00);
    end
    // The lock holds off while protected, then sets once allowed.
    wp = 1'b1;
    run(8'h6A, 8'h00, 8'h00, 5'h01);
    check({7'h00, prot_locked}, 8'h00);
    wp = 1'b0;
    run(8'h6A, 8'h00, 8'h00, 5'h01);
    check({6'h00, standby, prot_locked}, 8'h03);
    close_out();
  end

  // The commands above need about 94,000 cycles; this leaves a small margin.
  initial begin
    repeat (99000) @(posedge clock);
    err_count++;
    $display("mismatch at %0t ns: command sequence hung", $time);
    close_out();
  end
endmodule : pdss_test
